// file: hdl/pwc_top.sv
// modulator block: register file, four-channel unit and two tone units
//
// Overview of operation
// - share bit picks channel 0 compare value
// - enable bit 2 runs second tone unit
// - enable bit 1 runs first tone unit
// - enable bit 0 runs, clearing stops and clears
// - level select sets output level at overflow
// - channel enable bit gates channel output
// - count up, toggle at compare, wrap after period
// - zero compare 0%, above period 100%
// - tone high and low counts form period
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "pwc_map.svh"
module pwc_top (
  input  wire logic               clk_in,            // system clock
  input  wire logic               nrst_in,           // async reset, active low
  input  wire pwc_pkg::pwc_byte_t addr_in,           // register byte address
  input  wire pwc_pkg::pwc_byte_t wdata_in,          // write data
  input  wire logic               wr_in,             // write strobe
  input  wire logic               rd_in,             // read strobe
  output pwc_pkg::pwc_byte_t      rdata_out,         // read data, cycle after strobe
  output logic                    quad_output_a_out, // channel 0
  output logic                    quad_output_b_out, // channel 1
  output logic                    quad_output_c_out, // channel 2
  output logic                    quad_output_d_out, // channel 3
  output logic                    first_tone_out,    // first tone unit
  output logic                    second_tone_out    // second tone unit
);
  import pwc_pkg::*;

  pwc_state_s       st_reg;  // registered state
  pwc_state_s       st_next; // next state
  logic [3:0][15:0] eff_cmp; // compare value each channel really uses
  logic [7:0]       rd_mux;  // byte selected for a read

  // ****************************************************************
  // duty source selection
  // ****************************************************************
  // channel 0 always uses its own value; 1..3 may borrow channel 0's
  always_comb begin
    eff_cmp[0] = st_reg.cmp[0];
    for (int n = 1; n < 4; n++) begin
      eff_cmp[n] = st_reg.en[`PWC_EN_SHARE1 + n - 1] ? st_reg.cmp[0] : st_reg.cmp[n];
    end
  end

  // ****************************************************************
  // register file, counter and channel outputs
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    rd_mux  = 8'h00;
    // address decode; unmapped addresses read zero and drop writes
    unique case (addr_in)
      `PWC_A_T1_LO_L: begin
        rd_mux = st_reg.tlo[0][7:0];
        if (wr_in) st_next.tlo[0][7:0] = wdata_in;
      end
      `PWC_A_T1_LO_H: begin
        rd_mux = st_reg.tlo[0][15:8];
        if (wr_in) st_next.tlo[0][15:8] = wdata_in;
      end
      `PWC_A_T1_HI_L: begin
        rd_mux = st_reg.thi[0][7:0];
        if (wr_in) st_next.thi[0][7:0] = wdata_in;
      end
      `PWC_A_T1_HI_H: begin
        rd_mux = st_reg.thi[0][15:8];
        if (wr_in) st_next.thi[0][15:8] = wdata_in;
      end
      `PWC_A_T2_LO_L: begin
        rd_mux = st_reg.tlo[1][7:0];
        if (wr_in) st_next.tlo[1][7:0] = wdata_in;
      end
      `PWC_A_T2_LO_H: begin
        rd_mux = st_reg.tlo[1][15:8];
        if (wr_in) st_next.tlo[1][15:8] = wdata_in;
      end
      `PWC_A_T2_HI_L: begin
        rd_mux = st_reg.thi[1][7:0];
        if (wr_in) st_next.thi[1][7:0] = wdata_in;
      end
      `PWC_A_T2_HI_H: begin
        rd_mux = st_reg.thi[1][15:8];
        if (wr_in) st_next.thi[1][15:8] = wdata_in;
      end
      `PWC_A_ENABLE: begin
        // upper two bits are not built: read zero, writes ignored
        rd_mux = {2'b00, st_reg.en};
        if (wr_in) st_next.en = wdata_in[`PWC_EN_WIDTH-1:0];
      end
      `PWC_A_QCTRL: begin
        rd_mux = st_reg.ctrl;
        if (wr_in) st_next.ctrl = wdata_in;
      end
      `PWC_A_C0_L: begin
        rd_mux = st_reg.cmp[0][7:0];
        if (wr_in) st_next.cmp[0][7:0] = wdata_in;
      end
      `PWC_A_C0_H: begin
        rd_mux = st_reg.cmp[0][15:8];
        if (wr_in) st_next.cmp[0][15:8] = wdata_in;
      end
      `PWC_A_C1_L: begin
        rd_mux = st_reg.cmp[1][7:0];
        if (wr_in) st_next.cmp[1][7:0] = wdata_in;
      end
      `PWC_A_C1_H: begin
        rd_mux = st_reg.cmp[1][15:8];
        if (wr_in) st_next.cmp[1][15:8] = wdata_in;
      end
      `PWC_A_C2_L: begin
        rd_mux = st_reg.cmp[2][7:0];
        if (wr_in) st_next.cmp[2][7:0] = wdata_in;
      end
      `PWC_A_C2_H: begin
        rd_mux = st_reg.cmp[2][15:8];
        if (wr_in) st_next.cmp[2][15:8] = wdata_in;
      end
      `PWC_A_C3_L: begin
        rd_mux = st_reg.cmp[3][7:0];
        if (wr_in) st_next.cmp[3][7:0] = wdata_in;
      end
      `PWC_A_C3_H: begin
        rd_mux = st_reg.cmp[3][15:8];
        if (wr_in) st_next.cmp[3][15:8] = wdata_in;
      end
      `PWC_A_PER_L: begin
        rd_mux = st_reg.period[7:0];
        if (wr_in) st_next.period[7:0] = wdata_in;
      end
      `PWC_A_PER_H: begin
        rd_mux = st_reg.period[15:8];
        if (wr_in) st_next.period[15:8] = wdata_in;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
    // read data live for exactly one cycle after the strobe
    st_next.rdata = rd_in ? rd_mux : 8'h00;

    // shared counter: cleared while the unit is off
    if (!st_reg.en[`PWC_EN_QUAD]) begin
      st_next.cnt  = 16'h0000;
      st_next.qout = 4'h0;
    end else begin
      // period value plus one counts per cycle, then reload
      if (st_reg.cnt >= st_reg.period) begin
        st_next.cnt = 16'h0000;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
      // active until the compare value is reached; zero never active,
      // above the period always active
      for (int n = 0; n < 4; n++) begin
        if (!st_reg.ctrl[n]) begin
          st_next.qout[n] = 1'b0;
        end else begin
          st_next.qout[n] = (st_reg.cnt < eff_cmp[n])
                            ^ st_reg.ctrl[`PWC_POLA_BASE + n];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // tone units
  // ****************************************************************
  // each unit restarts from its high half whenever its enable is set again
  pwc_tone u_tone1 (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .en_in    (st_reg.en[`PWC_EN_TONE1]),
    .hi_in    (st_reg.thi[0]),
    .lo_in    (st_reg.tlo[0]),
    .tone_out (first_tone_out)
  );
  pwc_tone u_tone2 (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .en_in    (st_reg.en[`PWC_EN_TONE2]),
    .hi_in    (st_reg.thi[1]),
    .lo_in    (st_reg.tlo[1]),
    .tone_out (second_tone_out)
  );

  // outputs straight from flip-flops
  assign rdata_out         = st_reg.rdata;
  assign quad_output_a_out = st_reg.qout[0];
  assign quad_output_b_out = st_reg.qout[1];
  assign quad_output_c_out = st_reg.qout[2];
  assign quad_output_d_out = st_reg.qout[3];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_quad_stop_clear: assert property (
    !st_reg.en[0] |=> st_reg.cnt == 16'h0000 && st_reg.qout == 4'h0)
    else $error("counter not cleared while unit off");
  a_count_step: assert property (
    (st_reg.en[0] && st_reg.cnt < st_reg.period) ##1 st_reg.en[0]
      |-> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("counter did not step by one");
  a_count_wrap: assert property (
    st_reg.en[0] && st_reg.cnt >= st_reg.period |=> st_reg.cnt == 16'h0000)
    else $error("counter did not reload after period");
  a_chan_gate: assert property (
    !st_reg.ctrl[2] |=> !quad_output_c_out)
    else $error("disabled channel drives output");
  a_zero_duty: assert property (
    st_reg.en[0] && st_reg.ctrl[0] && !st_reg.ctrl[4] && st_reg.cmp[0] == 16'h0000
      |=> !quad_output_a_out)
    else $error("zero compare gave high output");
  a_wrap_level: assert property (
    st_reg.en[0] && st_reg.ctrl[3] && st_reg.cnt == 16'h0000 && eff_cmp[3] != 16'h0000
      |=> quad_output_d_out == !$past(st_reg.ctrl[7]))
    else $error("overflow level does not follow select");
  a_share_match: assert property (
    st_reg.en[0] && st_reg.en[3] && st_reg.ctrl[1:0] == 2'b11 && st_reg.ctrl[5] == st_reg.ctrl[4]
      |=> quad_output_b_out == quad_output_a_out)
    else $error("shared channel differs from channel 0");
  a_tone1_off: assert property (
    !st_reg.en[1] |=> !first_tone_out)
    else $error("first tone unit ran while off");
  a_tone2_off: assert property (
    !st_reg.en[2] |=> !second_tone_out)
    else $error("second tone unit ran while off");
  a_rsvd_zero: assert property (
    rd_in && addr_in == `PWC_A_ENABLE |=> rdata_out[7:6] == 2'b00)
    else $error("unbuilt enable bits read nonzero");
endmodule

// file: common/pwc_map.svh
// register offsets, field positions and reset values of the modulator block
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH

// ****************************************************************
// byte addresses of the control registers
// ****************************************************************
`define PWC_A_T1_LO_L 8'h99
`define PWC_A_T1_LO_H 8'h9A
`define PWC_A_T1_HI_L 8'h9B
`define PWC_A_T1_HI_H 8'h9C
`define PWC_A_T2_LO_L 8'h9D
`define PWC_A_T2_LO_H 8'h9E
`define PWC_A_T2_HI_L 8'h9F
`define PWC_A_T2_HI_H 8'hA1
`define PWC_A_ENABLE  8'hA2
`define PWC_A_QCTRL   8'hA3
`define PWC_A_C0_L    8'hA4
`define PWC_A_C0_H    8'hA5
`define PWC_A_C1_L    8'hA6
`define PWC_A_C1_H    8'hA7
`define PWC_A_C2_L    8'hA9
`define PWC_A_C2_H    8'hAA
`define PWC_A_C3_L    8'hAB
`define PWC_A_C3_H    8'hAC
`define PWC_A_PER_L   8'hAD
`define PWC_A_PER_H   8'hAE

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define PWC_EN_QUAD   0
`define PWC_EN_TONE1  1
`define PWC_EN_TONE2  2
`define PWC_EN_SHARE1 3
`define PWC_EN_WIDTH  6
`define PWC_POLA_BASE 4
`define PWC_RST_BYTE  8'h00
`define PWC_RST_WORD  16'h0000

`endif

// file: common/pwc_pkg.sv
// types shared by the modulator block
package pwc_pkg;
  typedef logic [7:0]  pwc_byte_t; // one register byte
  typedef logic [15:0] pwc_word_t; // one 16-bit count

  // whole state of the four-channel unit and its register file
  typedef struct packed {
    logic [5:0]       en;     // enable and share byte, bits 5..0
    logic [7:0]       ctrl;   // level select 7..4, channel enable 3..0
    logic [3:0][15:0] cmp;    // per-channel compare values
    logic [15:0]      period; // shared period value
    logic [1:0][15:0] thi;    // tone high times
    logic [1:0][15:0] tlo;    // tone low times
    logic [15:0]      cnt;    // shared up-counter
    logic [3:0]       qout;   // channel output levels
    logic [7:0]       rdata;  // read data register
  } pwc_state_s;

  // tone phase, one-hot
  typedef enum logic [1:0] {
    PWC_PH_HIGH = 2'b01,
    PWC_PH_LOW  = 2'b10
  } pwc_phase_e;

  // whole state of one tone unit
  typedef struct packed {
    pwc_phase_e ph;  // current half of the period
    logic [15:0] cnt; // cycles spent in that half
    logic        out; // output level
  } pwc_tone_s;
endpackage

// file: hdl/pwc_tone.sv
// single-channel high/low time modulator
`timescale 1ns/1ps
module pwc_tone (
  input  wire logic              clk_in,   // system clock
  input  wire logic              nrst_in,  // async reset, active low
  input  wire logic              en_in,    // unit enable
  input  wire pwc_pkg::pwc_word_t hi_in,   // high time in cycles
  input  wire pwc_pkg::pwc_word_t lo_in,   // low time in cycles
  output logic                   tone_out  // modulated output
);
  import pwc_pkg::*;

  pwc_tone_s st_reg;  // registered state
  pwc_tone_s st_next; // next state

  // ****************************************************************
  // phase sequencer
  // ****************************************************************
  // disabling clears the counter, so re-enabling after new times restarts cleanly
  always_comb begin
    st_next = st_reg;
    if (!en_in) begin
      st_next.ph  = PWC_PH_HIGH;
      st_next.cnt = 16'h0000;
      st_next.out = 1'b0;
    end else begin
      unique case (st_reg.ph)
        PWC_PH_HIGH: begin
          // output follows the half one cycle late, so the first half after
          // enable is as long as every later one; a zero high time stays low
          st_next.out = (hi_in != 16'h0000);
          if (hi_in == 16'h0000 || st_reg.cnt >= hi_in - 16'h0001) begin
            st_next.ph  = PWC_PH_LOW;
            st_next.cnt = 16'h0000;
          end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end
        PWC_PH_LOW: begin
          // a zero low time keeps the output high
          st_next.out = (lo_in == 16'h0000);
          if (lo_in == 16'h0000 || st_reg.cnt >= lo_in - 16'h0001) begin
            st_next.ph  = PWC_PH_HIGH;
            st_next.cnt = 16'h0000;
          end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end
        default: begin
          st_next.ph  = PWC_PH_HIGH;
          st_next.cnt = 16'h0000;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '{ph: PWC_PH_HIGH, cnt: 16'h0000, out: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tone_out = st_reg.out;
endmodule

// file: verif/pwc_top_bench.sv
// self-checking bench of the modulator block with a cycle model beside it
`timescale 1ns/1ps
`include "pwc_map.svh"
module pwc_top_bench;
  import pwc_pkg::*;
  // ****************************************************************
  // stimulus, design and mirror state
  // ****************************************************************
  logic       clk_in   = 1'b0;   // 25 MHz system clock
  logic       nrst_in  = 1'b0;   // reset, active low
  pwc_byte_t  addr_in  = 8'h00;  // bus address
  pwc_byte_t  wdata_in = 8'h00;  // bus write data
  logic       wr_in    = 1'b0;   // write strobe
  logic       rd_in    = 1'b0;   // read strobe
  pwc_byte_t  rdata_out;         // read data from the design
  logic       qa, qb, qc, qd;    // channel outputs
  logic       t1, t2;            // tone outputs
  logic [7:0] regs [256];        // mirror of the register bytes
  logic [3:0] m_q;               // expected channel outputs
  logic [15:0] m_cnt;            // expected shared counter
  logic [1:0] t_ph, t_out;       // expected tone phase (1 = high) and level
  logic [15:0] t_cnt [2];        // expected tone half counters
  pwc_byte_t  m_rd;              // expected read data
  int         n_errors    = 0;   // mismatches
  int         comparisons = 0;   // checks made
  integer     seed        = 32'h9368;
  localparam pwc_byte_t CL [4] = '{`PWC_A_C0_L, `PWC_A_C1_L, `PWC_A_C2_L, `PWC_A_C3_L};

  always #20 clk_in = ~clk_in;

  pwc_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .quad_output_a_out(qa),
    .quad_output_b_out(qb), .quad_output_c_out(qc), .quad_output_d_out(qd),
    .first_tone_out(t1), .second_tone_out(t2));

  // ****************************************************************
  // helpers of the mirror
  // ****************************************************************
  // holes in the map read zero, so the mirror must know them
  function automatic logic mapped(input pwc_byte_t a);
    return a inside {[8'h99:8'h9F], [8'hA1:8'hA7], [8'hA9:8'hAE]};
  endfunction
  function automatic logic [15:0] w16(input pwc_byte_t lo, input pwc_byte_t hi);
    return {regs[hi], regs[lo]};
  endfunction
  function automatic logic [15:0] rnd(input int n);
    return 16'($unsigned($random(seed)) % n);
  endfunction

  // mirror steps on the same edge as the design, from pre-edge values
  always @(posedge clk_in or negedge nrst_in) begin : model
    logic [15:0] eff;
    logic [15:0] tlen;
    if (!nrst_in) begin
      foreach (regs[i]) regs[i] <= 8'h00;
      m_q   <= 4'h0;
      m_cnt <= 16'h0000;
      m_rd  <= 8'h00;
      t_ph  <= 2'b11;
      t_out <= 2'b00;
      t_cnt <= '{16'h0000, 16'h0000};
    end else begin
      m_rd <= (rd_in && mapped(addr_in)) ? regs[addr_in] : 8'h00;
      for (int n = 0; n < 4; n++) begin
        // channels 1..3 may borrow the duty of channel 0
        eff = (n > 0 && regs[`PWC_A_ENABLE][n+2]) ? w16(CL[0], CL[0] + 8'h01)
                                                   : w16(CL[n], CL[n] + 8'h01);
        m_q[n] <= regs[`PWC_A_ENABLE][0] & regs[`PWC_A_QCTRL][n]
                  & ((m_cnt < eff) ^ regs[`PWC_A_QCTRL][n+4]);
      end
      if (!regs[`PWC_A_ENABLE][0] || m_cnt == w16(`PWC_A_PER_L, `PWC_A_PER_H)) begin
        m_cnt <= 16'h0000;
      end else begin
        m_cnt <= m_cnt + 16'h0001;
      end
      for (int k = 0; k < 2; k++) begin
        // length of the current half: high or low time of this unit
        if (k == 0) begin
          tlen = t_ph[0] ? w16(`PWC_A_T1_HI_L, `PWC_A_T1_HI_H)
                         : w16(`PWC_A_T1_LO_L, `PWC_A_T1_LO_H);
        end else begin
          tlen = t_ph[1] ? w16(`PWC_A_T2_HI_L, `PWC_A_T2_HI_H)
                         : w16(`PWC_A_T2_LO_L, `PWC_A_T2_LO_H);
        end
        if (!regs[`PWC_A_ENABLE][k+1]) begin
          t_ph[k]  <= 1'b1;
          t_cnt[k] <= 16'h0000;
          t_out[k] <= 1'b0;
        end else begin
          t_out[k] <= t_ph[k];
          t_ph[k]  <= (t_cnt[k] + 16'h0001 >= tlen) ? ~t_ph[k] : t_ph[k];
          t_cnt[k] <= (t_cnt[k] + 16'h0001 >= tlen) ? 16'h0000 : t_cnt[k] + 16'h0001;
        end
      end
      // bits 7..6 of the enable byte do not exist, so they never stick
      if (wr_in && mapped(addr_in)) begin
        regs[addr_in] <= (addr_in == `PWC_A_ENABLE) ? (wdata_in & 8'h3F) : wdata_in;
      end
    end
  end

  // ****************************************************************
  // comparison and closing
  // ****************************************************************
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // outputs are settled half a period after the edge
  always @(negedge clk_in) begin
    if (nrst_in) begin
      check("rdata", rdata_out, m_rd);
      check("quad a", 8'(qa), 8'(m_q[0]));
      check("quad b", 8'(qb), 8'(m_q[1]));
      check("quad c", 8'(qc), 8'(m_q[2]));
      check("quad d", 8'(qd), 8'(m_q[3]));
      check("tone 1", 8'(t1), 8'(t_out[0]));
      check("tone 2", 8'(t2), 8'(t_out[1]));
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // bus driver
  // ****************************************************************
  // one call is one cycle; consecutive calls give back-to-back strobes
  task automatic bus_op(input logic w, input logic r, input pwc_byte_t a, input pwc_byte_t d);
    @(posedge clk_in);
    wr_in    <= w;
    rd_in    <= r;
    addr_in  <= a;
    wdata_in <= d;
  endtask
  task automatic set16(input pwc_byte_t lo, input pwc_byte_t hi, input logic [15:0] v);
    bus_op(1'b1, 1'b0, lo, v[7:0]);
    bus_op(1'b1, 1'b0, hi, v[15:8]);
  endtask

  // safety net against a hung run
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end

  initial begin : main
    logic [15:0] r;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    // reset values, holes of the map included
    for (int a = 8'h98; a < 8'hB0; a++) bus_op(1'b0, 1'b1, 8'(a), 8'h00);
    $display("test reset values done");
    // period 3, duty 2 on channel 0: high two cycles, low two
    set16(`PWC_A_PER_L, `PWC_A_PER_H, 16'h0003);
    set16(CL[0], CL[0] + 8'h01, 16'h0002);
    bus_op(1'b1, 1'b0, `PWC_A_QCTRL, 8'h01);
    bus_op(1'b1, 1'b0, `PWC_A_ENABLE, 8'h01);
    bus_op(1'b0, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      #1 check("walk a", 8'(qa), 8'((5'b10011 >> i) & 5'b00001));
    end
    bus_op(1'b1, 1'b0, `PWC_A_ENABLE, 8'h00);
    bus_op(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge clk_in);
    #1 check("stop a", 8'(qa), 8'h00);
    $display("test counter walk done");
    // random episodes; times and period change only while stopped
    for (int e = 0; e < 40; e++) begin
      bus_op(1'b1, 1'b0, `PWC_A_ENABLE, 8'h00);
      set16(`PWC_A_T1_HI_L, `PWC_A_T1_HI_H, rnd(6) + 16'h0001);
      set16(`PWC_A_T1_LO_L, `PWC_A_T1_LO_H, rnd(6) + 16'h0001);
      set16(`PWC_A_T2_HI_L, `PWC_A_T2_HI_H, rnd(6) + 16'h0001);
      set16(`PWC_A_T2_LO_L, `PWC_A_T2_LO_H, rnd(6) + 16'h0001);
      set16(`PWC_A_PER_L, `PWC_A_PER_H, rnd(7));
      // compare values span zero and beyond the period
      for (int n = 0; n < 4; n++) set16(CL[n], CL[n] + 8'h01, rnd(9));
      bus_op(1'b1, 1'b0, `PWC_A_QCTRL, 8'(rnd(256)));
      bus_op(1'b1, 1'b0, `PWC_A_ENABLE, 8'(rnd(256)));
      repeat (40) begin
        r = rnd(8);
        if (r == 16'h0000) begin
          bus_op(1'b1, 1'b0, rnd(2) ? `PWC_A_QCTRL : `PWC_A_ENABLE, 8'(rnd(256)));
        end else if (r < 16'h0003) begin
          bus_op(1'b0, 1'b1, 8'h98 + 8'(rnd(24)), 8'h00);
        end else begin
          bus_op(1'b0, 1'b0, 8'h00, 8'h00);
        end
      end
    end
    bus_op(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge clk_in);
    $display("test random episodes done");
    // reset in mid-run must bring every output and the bytes A1..A4 back to zero
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int a = 8'hA1; a < 8'hA5; a++) bus_op(1'b0, 1'b1, 8'(a), 8'h00);
    bus_op(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge clk_in);
    #1 check("reset q", 8'({qa, qb, qc, qd, t1, t2}), 8'h00);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
